/* File: include/rtfop_pkg.sv */
/*
 rtfop_pkg: constants, enums and coefficient tables of the real-time
 spectrum pipeline.
 assumes: a single 50 MHz clock domain; importers pull in rtfop_pkg::*.
*/
package rtfop_pkg;
   // clocking and throughput
   localparam int CLK_HZ         = 50_000_000;
   localparam int ADC_RATE_MSPS  = 2400;       // nominal converter rate
   localparam int ADC_W          = 14;         // converter sample width
   localparam int FFT_RATE_HZ    = 293_000;    // transforms per second
   localparam int FFT_BUDGET_CYC = CLK_HZ / FFT_RATE_HZ; // rounds down
   // datapath widths
   localparam int SMP_W        = 16;           // corrected sample width
   localparam int DEC_MAX_LOG2 = 7;            // largest decimation shift
   localparam int DEC_W        = ADC_W + DEC_MAX_LOG2;
   localparam int REC_AW       = 4;            // record of 16 samples
   localparam int BUF_AW       = 5;            // overlap memory, 32 words
   localparam int BIN_AW       = 3;            // 8 output bins
   localparam int NBIN         = 8;
   localparam int ACC_W        = 24;           // bin accumulator width
   localparam int POW_W        = 32;           // bin power width
   localparam int POW_SHIFT    = 11;           // power scaling
   localparam int CORR_FRAC    = 14;           // gain is q2.14
   localparam int COEF_FRAC    = 15;           // window is q0.15
   localparam int TWID_FRAC    = 14;           // twiddle is q2.14
   localparam int DENS_W       = 16;           // density hit counter
   localparam int DENS_AW      = 5;            // 8 bins x 4 levels
   localparam logic [REC_AW:0]   REC_FULL = 5'h10;  // record length
   localparam logic [REC_AW-1:0] SIN_OFS  = 4'hC;   // sine = cos - 90 deg
   localparam logic [REC_AW-1:0] N_LAST   = 4'hF;
   localparam logic [BIN_AW-1:0] K_LAST   = 3'h7;
   localparam logic [15:0]       DENS_MAX = 16'hFFFF;
   // display read selects
   localparam logic [1:0] DISP_SPEC = 2'h0;
   localparam logic [1:0] DISP_DENS = 2'h1;
   localparam logic [1:0] DISP_PVT  = 2'h2;
   localparam logic [1:0] DISP_MASK = 2'h3;
   // window shapes
   typedef enum logic [2:0] {
      WIN_GAUSS = 3'h0, WIN_FLAT = 3'h1, WIN_BHARRIS = 3'h2,
      WIN_RECT  = 3'h3, WIN_HANN = 3'h4, WIN_KAISER  = 3'h5
   } rtfop_win_type;
   // transform sequencer, gray along idle-calc-power
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0, ST_CALC = 2'h1, ST_POWR = 2'h3
   } rtfop_st_type;
   // half windows, edge first; the second half mirrors the first
   localparam logic [15:0] WIN_LUT [6][8] = '{
      '{16'h1000, 16'h1C00, 16'h2C00, 16'h4000, 16'h5400, 16'h6800, 16'h7600, 16'h7E00},
      '{16'h0000, 16'h0080, 16'h0600, 16'h1700, 16'h3500, 16'h5A00, 16'h7700, 16'h7FFF},
      '{16'h0002, 16'h0100, 16'h0700, 16'h1800, 16'h3600, 16'h5800, 16'h7200, 16'h7F00},
      '{16'h7FFF, 16'h7FFF, 16'h7FFF, 16'h7FFF, 16'h7FFF, 16'h7FFF, 16'h7FFF, 16'h7FFF},
      '{16'h0000, 16'h0560, 16'h1450, 16'h2A00, 16'h43C0, 16'h5D30, 16'h7100, 16'h7CC0},
      '{16'h0A00, 16'h1800, 16'h2C00, 16'h4300, 16'h5A00, 16'h6C00, 16'h7800, 16'h7E00}
   };
   // one full cosine turn in 16 steps
   localparam logic signed [15:0] COS_LUT [16] = '{
      16'h4000, 16'h3B21, 16'h2D41, 16'h187E, 16'h0000, 16'hE782, 16'hD2BF, 16'hC4DF,
      16'hC000, 16'hC4DF, 16'hD2BF, 16'hE782, 16'h0000, 16'h187E, 16'h2D41, 16'h3B21
   };
endpackage

/* File: rtl/rtfop_pipeline.sv */
/*
 rtfop_pipeline: spectrum pipeline, gap-free until ovr_o flags a loss. decimates and corrects a
 sample stream, forks it to a time output and an overlap memory, windows
 and transforms each record, and feeds spectrum, density and pvt traces
 plus a mask trigger. a display port reads the traces back.
 assumes: samples arrive on sys_clk_i from same-clock front-end logic, at
 most one per cycle; mask limits come from a configuration master.
*/
// Contract
// - accept every 14-bit signed input sample
// - fork corrected stream into frequency, time
// - overlap memory builds records for transform
// - transform fits the 293k per second budget
// - results go to three traces, trigger
// - mask trigger checks every spectrum
// - display processor reads accumulated traces
// - window multiplies samples before transform
// - six selectable window shapes
// - record processing keeps analysis gap free; code flags ovr_o once over 16 samples arrive in one transform
// - records are contiguous consecutive samples
// - new records reuse newest previous samples
// - overlap 0 to 100 percent, 1-sample steps
// - spare capacity runs extra overlapped transforms
`timescale 1ns/100ps
module rtfop_pipeline
   import rtfop_pkg::*;
(
   // clock and reset
   input  wire logic                     sys_clk_i,
   input  wire logic                     rst_n_i,
   // converter stream
   input  wire logic                     adc_vld_i,
   input  wire logic signed [ADC_W-1:0]  adc_data_i,
   // front-end setup
   input  wire logic                     rt_en_i,
   input  wire logic [2:0]               decim_log2_i,
   input  wire logic signed [SMP_W-1:0]  gain_i,
   input  wire logic signed [SMP_W-1:0]  offset_i,
   // record setup
   input  wire logic [REC_AW:0]          overlap_i,
   input  wire logic [2:0]               win_sel_i,
   // mask setup
   input  wire logic                     mask_en_i,
   input  wire logic                     mask_wr_i,
   input  wire logic [BIN_AW-1:0]        mask_addr_i,
   input  wire logic [POW_W-1:0]         mask_data_i,
   // status
   input  wire logic                     ovr_clr_i,
   output logic                          ovr_o,
   output logic                          busy_o,
   // time branch
   output logic                          time_vld_o,
   output logic [SMP_W-1:0]              time_data_o,
   // result stream
   output logic                          res_vld_o,
   output logic [BIN_AW-1:0]             res_bin_o,
   output logic [POW_W-1:0]              res_pow_o,
   output logic                          trig_o,
   // display port
   input  wire logic                     disp_rd_i,
   input  wire logic [1:0]               disp_sel_i,
   input  wire logic [DENS_AW-1:0]       disp_addr_i,
   input  wire logic                     dens_clr_i,
   output logic                          disp_vld_o,
   output logic [POW_W-1:0]              disp_data_o
);

   // whole block state in one record
   typedef struct packed {
      logic signed [DEC_W-1:0]         dec_acc;   // decimator sum
      logic [DEC_MAX_LOG2-1:0]         dec_cnt;   // samples in sum
      logic                            corr_vld;  // corrected sample ready
      logic [SMP_W-1:0]                corr;      // corrected sample
      logic [31:0][SMP_W-1:0]          ovl_mem;   // overlap memory
      logic [BUF_AW-1:0]               wp;        // overlap write pointer
      logic [BUF_AW-1:0]               base;      // record start address
      logic [REC_AW:0]                 fill;      // primed depth
      logic [REC_AW:0]                 new_cnt;   // arrivals since launch
      rtfop_st_type                    st;        // sequencer state
      logic [REC_AW-1:0]               n;         // sample index
      logic [BIN_AW-1:0]               k;         // bin index
      rtfop_win_type                   win;       // window of this record
      logic signed [ACC_W-1:0]         re;        // bin real sum
      logic signed [ACC_W-1:0]         im;        // bin imag sum
      logic [POW_W-1:0]                pvt_sum;   // record power so far
      logic                            hit;       // mask exceeded so far
      logic [NBIN-1:0][POW_W-1:0]      spec;      // spectrum trace
      logic [NBIN-1:0][POW_W-1:0]      pvt;       // power versus time trace
      logic [NBIN-1:0][POW_W-1:0]      mask;      // limit mask
      logic [BIN_AW-1:0]               pvt_wp;    // pvt write slot
      logic [31:0][DENS_W-1:0]         dens;      // density hit counts
      logic                            res_vld;
      logic [BIN_AW-1:0]               res_bin;
      logic [POW_W-1:0]                res_pow;
      logic                            trig;
      logic                            ovr;
      logic                            disp_vld;
      logic [POW_W-1:0]                disp_data;
   } rtfop_state_type;

   rtfop_state_type         s_r;        // registered state
   rtfop_state_type         s_nxt;      // next state
   logic [DEC_MAX_LOG2-1:0] dec_top;    // last count of a decimation group
   logic                    dec_last;   // this sample closes a group
   logic [REC_AW:0]         ovl_c;      // overlap clamped to record length
   logic [REC_AW:0]         hop;        // new samples needed per record
   logic                    launch;     // start a transform now
   logic                    ovr_set;    // a record sample is overwritten
   logic [POW_W-1:0]        disp_peek;  // spectrum word under the read address

   // group size is a power of two so the average is a plain shift
   assign dec_top  = ~({DEC_MAX_LOG2{1'b1}} << decim_log2_i);
   assign dec_last = (s_r.dec_cnt >= dec_top);
   assign ovl_c    = (overlap_i > REC_FULL) ? REC_FULL : overlap_i;
   assign hop      = REC_FULL - ovl_c;
   // idle engine takes a record as soon as enough new samples exist
   assign launch   = (s_r.st == ST_IDLE) && rt_en_i && (s_r.fill == REC_FULL)
                     && (s_r.new_cnt >= hop);
   // the 17th write after launch lands on the record still being read
   assign ovr_set  = s_r.corr_vld && (s_r.st != ST_IDLE)
                     && (s_r.new_cnt >= REC_FULL);
   assign disp_peek = s_r.spec[disp_addr_i[BIN_AW-1:0]];

   // next-state logic for the whole pipeline
   always_comb begin
      logic signed [DEC_W-1:0]     dsum;
      logic signed [DEC_W-1:0]     dec;
      logic signed [SMP_W:0]       ofs_sum;
      logic signed [2*SMP_W:0]     cprod;
      logic [BUF_AW-1:0]           rd_a;
      logic [BIN_AW-1:0]           half;
      logic signed [2*SMP_W:0]     wprod;
      logic signed [SMP_W-1:0]     wsmp;
      logic [REC_AW-1:0]           tw;
      logic signed [2*SMP_W-1:0]   tre;
      logic signed [2*SMP_W-1:0]   tim;
      logic [2*ACC_W:0]            psum;
      logic [POW_W-1:0]            pow;
      logic [DENS_AW-1:0]          da;
      logic                        over;
      logic [POW_W-1:0]            pacc;
      dsum    = s_r.dec_acc + DEC_W'(adc_data_i);
      dec     = dsum >>> decim_log2_i;
      ofs_sum = $signed({dec[SMP_W-1], dec[SMP_W-1:0]})
                + $signed({offset_i[SMP_W-1], offset_i});
      cprod   = ofs_sum * gain_i;
      rd_a    = s_r.base + BUF_AW'(s_r.n);
      // mirrored index: positions 8..15 reuse the first half
      half    = s_r.n[REC_AW-1] ? ~s_r.n[BIN_AW-1:0] : s_r.n[BIN_AW-1:0];
      wprod   = $signed(s_r.ovl_mem[rd_a])
                * $signed({1'b0, WIN_LUT[s_r.win][half]});
      wsmp    = wprod[COEF_FRAC +: SMP_W];
      tw      = REC_AW'(s_r.k * s_r.n);
      tre     = wsmp * COS_LUT[tw];
      tim     = wsmp * COS_LUT[REC_AW'(tw + SIN_OFS)];
      psum    = s_r.re * s_r.re + s_r.im * s_r.im;
      pow     = psum[POW_SHIFT +: POW_W];
      // coarse amplitude level picks the density row
      if (|pow[31:24]) begin
         da = {s_r.k, 2'h3};
      end else if (|pow[23:16]) begin
         da = {s_r.k, 2'h2};
      end else if (|pow[15:8]) begin
         da = {s_r.k, 2'h1};
      end else begin
         da = {s_r.k, 2'h0};
      end
      over    = mask_en_i && (pow > s_r.mask[s_r.k]);
      pacc    = s_r.pvt_sum + (pow >> BIN_AW);

      s_nxt          = s_r;
      s_nxt.corr_vld = 1'b0;
      s_nxt.res_vld  = 1'b0;
      s_nxt.trig     = 1'b0;
      s_nxt.disp_vld = 1'b0;

      // decimate by averaging, then offset and gain correction
      if (rt_en_i && adc_vld_i) begin
         if (dec_last) begin
            s_nxt.dec_acc  = '0;
            s_nxt.dec_cnt  = '0;
            s_nxt.corr_vld = 1'b1;
            s_nxt.corr     = cprod[CORR_FRAC +: SMP_W];
         end else begin
            s_nxt.dec_acc  = dsum;
            s_nxt.dec_cnt  = s_r.dec_cnt + 1'b1;
         end
      end

      // frequency branch: every corrected sample enters the overlap memory
      if (s_r.corr_vld) begin
         s_nxt.ovl_mem[s_r.wp] = s_r.corr;
         s_nxt.wp = s_r.wp + 1'b1;
         if (s_r.fill != REC_FULL) begin
            s_nxt.fill = s_r.fill + 1'b1;
         end
         if (s_r.new_cnt != REC_FULL) begin
            s_nxt.new_cnt = s_r.new_cnt + 1'b1;
         end
      end
      // leaving real-time mode drops the priming, the next run refills
      if (!rt_en_i) begin
         s_nxt.fill    = '0;
         s_nxt.new_cnt = '0;
         s_nxt.dec_acc = '0;
         s_nxt.dec_cnt = '0;
      end

      // sticky overrun; a new loss beats a clear in the same cycle
      s_nxt.ovr = (s_r.ovr && !ovr_clr_i) || ovr_set;

      // transform sequencer: 16 products per bin, then one power cycle
      case (s_r.st)
         ST_IDLE: begin
            if (launch) begin
               s_nxt.st      = ST_CALC;
               s_nxt.base    = s_r.wp - BUF_AW'(REC_FULL);
               s_nxt.new_cnt = {{REC_AW{1'b0}}, s_r.corr_vld};
               s_nxt.n       = '0;
               s_nxt.k       = '0;
               // unknown codes fall back to the plain window
               s_nxt.win     = (win_sel_i > WIN_KAISER) ? WIN_RECT
                               : rtfop_win_type'(win_sel_i);
            end
         end
         ST_CALC: begin
            s_nxt.re = s_r.re + ACC_W'(tre >>> TWID_FRAC);
            s_nxt.im = s_r.im - ACC_W'(tim >>> TWID_FRAC);
            s_nxt.n  = s_r.n + 1'b1;
            if (s_r.n == N_LAST) begin
               s_nxt.st = ST_POWR;
            end
         end
         ST_POWR: begin
            // every result feeds spectrum, density, the pvt sum and the mask hit; the last bin writes pvt and fires the trigger
            s_nxt.res_vld   = 1'b1;
            s_nxt.res_bin   = s_r.k;
            s_nxt.res_pow   = pow;
            s_nxt.spec[s_r.k] = pow;
            if (dens_clr_i) begin
               s_nxt.dens = '0;
            end
            if (s_nxt.dens[da] != DENS_MAX) begin
               s_nxt.dens[da] = s_nxt.dens[da] + 1'b1;
            end
            s_nxt.re = '0;
            s_nxt.im = '0;
            if (s_r.k == K_LAST) begin
               s_nxt.pvt[s_r.pvt_wp] = pacc;
               s_nxt.pvt_wp  = s_r.pvt_wp + 1'b1;
               s_nxt.trig    = s_r.hit || over;
               s_nxt.hit     = 1'b0;
               s_nxt.pvt_sum = '0;
               s_nxt.st      = ST_IDLE;
            end else begin
               s_nxt.hit     = s_r.hit || over;
               s_nxt.pvt_sum = pacc;
               s_nxt.k       = s_r.k + 1'b1;
               s_nxt.st      = ST_CALC;
            end
         end
         default: begin
            s_nxt.st = ST_IDLE;
         end
      endcase

      // clear outside a result cycle; a result cycle handles it above
      if (dens_clr_i && (s_r.st != ST_POWR)) begin
         s_nxt.dens = '0;
      end
      if (mask_wr_i) begin
         s_nxt.mask[mask_addr_i] = mask_data_i;
      end

      // display read, data one cycle after the request
      if (disp_rd_i) begin
         s_nxt.disp_vld = 1'b1;
         case (disp_sel_i)
            DISP_SPEC: s_nxt.disp_data = disp_addr_i[DENS_AW-1:BIN_AW] == 2'h0
                                         ? disp_peek : '0;
            DISP_PVT:  s_nxt.disp_data = disp_addr_i[DENS_AW-1:BIN_AW] == 2'h0
                                         ? s_r.pvt[disp_addr_i[BIN_AW-1:0]] : '0;
            DISP_MASK: s_nxt.disp_data = disp_addr_i[DENS_AW-1:BIN_AW] == 2'h0
                                         ? s_r.mask[disp_addr_i[BIN_AW-1:0]] : '0;
            default:   s_nxt.disp_data = {16'h0000, s_r.dens[disp_addr_i]};
         endcase
      end
   end

   // state register; the traces reset too so reads are defined
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // outputs straight from the state register
   assign ovr_o       = s_r.ovr;
   assign busy_o      = (s_r.st != ST_IDLE);
   assign time_vld_o  = s_r.corr_vld;
   assign time_data_o = s_r.corr;
   assign res_vld_o   = s_r.res_vld;
   assign res_bin_o   = s_r.res_bin;
   assign res_pow_o   = s_r.res_pow;
   assign trig_o      = s_r.trig;
   assign disp_vld_o  = s_r.disp_vld;
   assign disp_data_o = s_r.disp_data;

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);

   // a closing sample shows on the time branch next cycle
   AST_CORR_OUT: assert property (
      rt_en_i && adc_vld_i && dec_last |=> time_vld_o)
      else $error("closing sample produced no corrected output");

   // each corrected sample also enters the overlap memory
   AST_FORK: assert property (
      time_vld_o |=> s_r.wp == $past(s_r.wp) + 5'h01
                     && s_r.ovl_mem[$past(s_r.wp)] == $past(time_data_o))
      else $error("corrected sample missing from overlap memory");

   // a launched record is the newest 16 samples
   AST_RECORD: assert property (
      s_r.st == ST_IDLE ##1 s_r.st == ST_CALC
      |-> s_r.base == $past(s_r.wp) - 5'h10 && s_r.n == 4'h0)
      else $error("record does not start 16 samples back");

   // a full transform returns to idle within the rate budget
   AST_BUDGET: assert property (
      s_r.st == ST_IDLE ##1 s_r.st == ST_CALC |-> ##136 s_r.st == ST_IDLE)
      else $error("transform length differs from 136 cycles");

   // ready engine must take a due record at once
   AST_EXTRA: assert property (
      s_r.st == ST_IDLE && rt_en_i && s_r.fill == REC_FULL
      && s_r.new_cnt >= hop |=> s_r.st == ST_CALC)
      else $error("due record not launched");

   // a result is in the spectrum trace the moment it is announced
   AST_RES_PAR: assert property (
      res_vld_o |-> s_r.spec[res_bin_o] == res_pow_o)
      else $error("spectrum trace disagrees with result");

   // trigger only at the close of a whole spectrum
   AST_TRIG: assert property (
      trig_o |-> res_vld_o && res_bin_o == K_LAST && $past(mask_en_i))
      else $error("trigger outside a spectrum end");

   // display returns the spectrum word one cycle later
   AST_DISP: assert property (
      disp_rd_i && disp_sel_i == DISP_SPEC && disp_addr_i < 5'h08
      |=> disp_vld_o && disp_data_o == $past(disp_peek))
      else $error("display read returned wrong spectrum word");

   // window is held through a record
   AST_WIN_HOLD: assert property (
      s_r.st != ST_IDLE ##1 s_r.st != ST_IDLE |-> $stable(s_r.win))
      else $error("window changed inside a record");

   // overrun sticks until cleared
   AST_OVR: assert property (
      ovr_set or (ovr_o && !ovr_clr_i) |=> ovr_o)
      else $error("overrun flag lost");

endmodule

/* File: testbench/rtfop_adc_model.sv */
/*
 rtfop_adc_model: converter stand-in sending a constant sample level.
 assumes: bench clock; run_i changes at falling edges, data changes there too.
*/
`timescale 1ns/100ps
module rtfop_adc_model
   import rtfop_pkg::*;
(
   // bench side
   input  wire logic                    sys_clk_i,
   input  wire logic                    run_i,
   input  wire logic signed [ADC_W-1:0] level_i,
   // converter stream
   output logic                         adc_vld_o,
   output logic signed [ADC_W-1:0]      adc_data_o
);
   logic go;  // run seen at the rising edge, avoids a same-edge race
   initial begin
      go = 1'b0;
      adc_vld_o = 1'b0;
      adc_data_o = '0;
   end
   always @(posedge sys_clk_i) go <= run_i;
   // one sample a cycle; an idle bus shows the inverse, not stale data
   always @(negedge sys_clk_i) begin
      adc_vld_o <= go;
      adc_data_o <= go ? level_i : ~adc_data_o;
   end
endmodule

/* File: testbench/rtfop_pipeline_test.sv */
/*
 rtfop_pipeline_test: self-checking bench of the spectrum pipeline.
 assumes: rtfop_pkg compiled first; inputs driven at falling edges.
*/
`timescale 1ns/100ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_mismatch++; \
   $display("CHECK FAILED t=%0t got %0h exp %0h", $time, a, b); end end
module rtfop_pipeline_test
   import rtfop_pkg::*;
;
   logic sys_clk_i = 1'b0, rst_n_i = 1'b0, run = 1'b0, rt_en = 1'b0;
   logic signed [ADC_W-1:0] level = 14'h03E8;
   logic adc_vld, mask_wr = 1'b0, ovr_clr = 1'b0, disp_rd = 1'b0, dens_clr = 1'b0;
   logic signed [ADC_W-1:0] adc_data;
   logic [2:0] decim = 3'h0, win = 3'h3;
   logic signed [SMP_W-1:0] gain = 16'h4000, offset = 16'h0000;
   logic [REC_AW:0] ovl = 5'h00;
   logic [BIN_AW-1:0] mask_addr = 3'h0;
   logic [POW_W-1:0] mask_data = 32'h0, p0, pm, rdv, pw [7];
   logic [1:0] dsel = 2'h0;
   logic [DENS_AW-1:0] daddr = 5'h00;
   logic ovr_o, busy_o, time_vld_o, res_vld_o, trig_o, disp_vld_o, tg;
   logic [SMP_W-1:0] time_data_o;
   logic [BIN_AW-1:0] res_bin_o;
   logic [POW_W-1:0] res_pow_o, disp_data_o;
   int n_mismatch = 0, num_checks = 0, n_tv = 0, i;
   always #10 sys_clk_i = ~sys_clk_i;  // 50 MHz
   always @(posedge sys_clk_i) if (time_vld_o === 1'b1) n_tv++;
   rtfop_adc_model i_rtfop_adc_model (.sys_clk_i(sys_clk_i), .run_i(run),
      .level_i(level), .adc_vld_o(adc_vld), .adc_data_o(adc_data));
   rtfop_pipeline i_rtfop_pipeline (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
      .adc_vld_i(adc_vld), .adc_data_i(adc_data), .rt_en_i(rt_en),
      .decim_log2_i(decim), .gain_i(gain), .offset_i(offset), .overlap_i(ovl),
      .win_sel_i(win), .mask_en_i(1'b1), .mask_wr_i(mask_wr),
      .mask_addr_i(mask_addr), .mask_data_i(mask_data), .ovr_clr_i(ovr_clr),
      .ovr_o(ovr_o), .busy_o(busy_o), .time_vld_o(time_vld_o),
      .time_data_o(time_data_o), .res_vld_o(res_vld_o), .res_bin_o(res_bin_o),
      .res_pow_o(res_pow_o), .trig_o(trig_o), .disp_rd_i(disp_rd),
      .disp_sel_i(dsel), .disp_addr_i(daddr), .dens_clr_i(dens_clr),
      .disp_vld_o(disp_vld_o), .disp_data_o(disp_data_o));
   task automatic tick(input int n);
      repeat (n) @(negedge sys_clk_i);
   endtask
   task automatic feed(input int n);
      run = 1'b1;
      tick(n);
      run = 1'b0;
   endtask
   // restart priming so the next 16 samples form a fresh record
   task automatic prime();
      rt_en = 1'b0;
      tick(1);
      rt_en = 1'b1;
      feed(16);
   endtask
   // waits for a launch, then times and collects all bins
   task automatic rec();
      int t, k;
      t = 0;
      k = 0;
      pm = '0;
      while (busy_o !== 1'b1 && t < 40) begin tick(1); t++; end
      t = 0;
      while (k < NBIN && t < 200) begin
         tick(1);
         t++;
         if (res_vld_o === 1'b1) begin
            `CHK(t, 17 + 17 * k)
            `CHK(res_bin_o, 3'(k))
            if (k == 0) p0 = res_pow_o;
            else if (res_pow_o > pm) pm = res_pow_o;
            if (k == NBIN - 1) tg = trig_o;
            k++;
         end
      end
      `CHK(k, NBIN)
   endtask
   task automatic rd(input logic [1:0] s, input logic [DENS_AW-1:0] a);
      dsel = s;
      daddr = a;
      disp_rd = 1'b1;
      tick(1);
      disp_rd = 1'b0;
      `CHK(disp_vld_o, 1'b1)
      rdv = disp_data_o;
   endtask
   // refused while disabled, then offset, gain and decimation
   task automatic t_time();
      feed(4);
      tick(3);
      `CHK(n_tv, 0)
      rt_en = 1'b1;
      level = -14'sd5;
      gain = 16'h2000;
      offset = 16'h0003;
      feed(1);
      tick(3);
      `CHK(n_tv, 1)
      `CHK(time_data_o, 16'hFFFF)
      decim = 3'h2;
      feed(8);
      tick(3);
      `CHK(n_tv, 3)
      {decim, gain, offset, level} = {3'h0, 16'h4000, 16'h0000, 14'h03E8};
   endtask
   // every window shape, rect leaks nothing, trigger on a zero mask
   task automatic t_win();
      for (i = 0; i < 7; i++) begin
         win = 3'(i);
         prime();
         rec();
         pw[i] = p0;
         `CHK(tg, 1'b1)
         if (i == 3) `CHK(pm, 32'h0)
      end
      for (i = 0; i < 6; i++) if (i != 3) `CHK(pw[i] < pw[3], 1'b1)
      `CHK(pw[6], pw[3])
   endtask
   // high mask keeps the trigger quiet; density cleared, traces read back
   task automatic t_mask();
      mask_wr = 1'b1;
      dens_clr = 1'b1;
      mask_data = 32'hFFFFFFFF;
      for (i = 0; i < 8; i++) begin mask_addr = 3'(i); tick(1); end
      mask_wr = 1'b0;
      dens_clr = 1'b0;
      prime();
      rec();
      `CHK(tg, 1'b0)
      rd(DISP_MASK, 5'h02);
      `CHK(rdv, 32'hFFFFFFFF)
      rd(DISP_SPEC, 5'h00);
      `CHK(rdv != 0, 1'b1)
      rd(DISP_SPEC, 5'h08);
      `CHK(rdv, 32'h0)
      // plain window on a constant: bin 0 lands in level 2, bin 1 in level 0
      rd(DISP_DENS, 5'h02);
      `CHK(rdv, 32'h1)
      rd(DISP_DENS, 5'h04);
      `CHK(rdv, 32'h1)
      // eighth record of the run fills pvt slot 7, only bin 0 has power
      rd(DISP_PVT, 5'h07);
      `CHK(rdv, p0 >> 3)
   endtask
   // full overlap relaunches at once, half overlap waits for 8 new samples
   task automatic t_ovl();
      ovl = 5'h10;
      prime();
      rec();
      for (i = 0; i < 40 && busy_o === 1'b1; i++) tick(1);
      tick(3);
      `CHK(busy_o, 1'b1)
      ovl = 5'h08;
      for (i = 0; i < 200 && busy_o === 1'b1; i++) tick(1);
      feed(7);
      tick(20);
      `CHK(busy_o, 1'b0)
      feed(1);
      for (i = 0; i < 6 && busy_o !== 1'b1; i++) tick(1);
      `CHK(busy_o, 1'b1)
      for (i = 0; i < 200 && busy_o === 1'b1; i++) tick(1);
   endtask
   // samples keep coming during a transform: sticky flag, then clear
   task automatic t_ovr();
      ovl = 5'h00;
      `CHK(ovr_o, 1'b0)
      rt_en = 1'b0;
      tick(1);
      rt_en = 1'b1;
      feed(40);
      for (i = 0; i < 200 && busy_o === 1'b1; i++) tick(1);
      `CHK(ovr_o, 1'b1)
      ovr_clr = 1'b1;
      tick(1);
      ovr_clr = 1'b0;
      tick(1);
      `CHK(ovr_o, 1'b0)
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial begin
      tick(4);
      rst_n_i = 1'b1;
      tick(1);
      t_time();
      t_win();
      t_mask();
      t_ovl();
      t_ovr();
      finish_test();
   end
   // watchdog: the whole run needs about 1900 cycles
   initial begin
      tick(20000);
      n_mismatch++;
      finish_test();
   end
endmodule
